// *** hdl/nfa_pkg.sv ***
// package for the next-instruction field alter block
package nfa_pkg;
   localparam int FLD_W = 9;
   localparam int WORD_W = 32;
   localparam int BASE_LSB = 0;
   localparam int IDX_LSB = 9;
   localparam int BIT_LSB = 5;
   localparam int BYTE_LSB = 2;
   localparam int BITPOS_W = 5;
   localparam int BITIDX_W = 14;
   localparam int SEL_W = 2;
   localparam logic [4:0] RANGE_ZERO = 5'h0_0;
   localparam int RANGE_LSB = 5;
   localparam logic [8:0] ALLOW_CODE = 9'h0_24;

   typedef enum logic [2:0]
   {
      NFA_OP_DEST = 3'h1,
      NFA_OP_BIT = 3'h2,
      NFA_OP_BYTE = 3'h4
   } nfa_op_t;

   // one decoded alter request from the execute stage
   typedef struct packed
   {
      logic valid;
      nfa_op_t op;
      logic two_op;
      logic [WORD_W-1:0] dest;
      logic [WORD_W-1:0] src;
   } nfa_req_t;

   // substitution presented to the following instruction
   typedef struct packed
   {
      logic dest_en;
      logic [FLD_W-1:0] dest;
      logic src_en;
      logic [FLD_W-1:0] src;
      logic sel_en;
      logic [SEL_W-1:0] sel;
      logic range_zero;
   } nfa_sub_t;

   typedef enum logic [1:0]
   {
      NFA_IDLE = 2'h1,
      NFA_ARMED = 2'h2
   } nfa_state_t;
endpackage : nfa_pkg

// *** hdl/nfa_calc.sv ***
// substitution and post-adjust arithmetic for one alter request
`timescale 1ns/1ps
module nfa_calc
   import nfa_pkg::*;
(
   input wire nfa_req_t req,
   output nfa_sub_t sub,
   output logic [WORD_W-1:0] wb
);
   function automatic logic [FLD_W-1:0] add9(input logic [FLD_W-1:0] a, input logic [FLD_W-1:0] b);
      add9 = a + b;
   endfunction : add9

   logic [FLD_W-1:0] base;
   logic [FLD_W-1:0] inc;
   logic [FLD_W-1:0] fld;

   always_comb
   begin
      base = req.src[BASE_LSB +: FLD_W];
      inc = req.two_op ? req.src[IDX_LSB +: FLD_W] : '0;
      sub = '0;
      fld = '0;
      case (req.op)
         NFA_OP_DEST:
         begin
            fld = req.dest[FLD_W-1:0];
            sub.dest_en = 1'b1;
            sub.dest = req.two_op ? add9(base, fld) : fld;
         end
         NFA_OP_BIT:
         begin
            // low five bits stay with the bit op as its position
            fld = req.dest[BIT_LSB +: FLD_W];
            sub.dest_en = 1'b1;
            sub.dest = req.two_op ? add9(base, fld) : fld;
         end
         NFA_OP_BYTE:
         begin
            fld = req.dest[BYTE_LSB +: FLD_W];
            sub.src_en = 1'b1;
            sub.src = req.two_op ? add9(base, fld) : fld;
            sub.sel_en = 1'b1;
            sub.sel = req.dest[SEL_W-1:0];
         end
         default:
         begin
            sub = '0;
         end
      endcase
      wb = req.dest + {{(WORD_W-FLD_W){inc[FLD_W-1]}}, inc};
   end
endmodule : nfa_calc

// *** hdl/nfa_top.sv ***
// next-instruction field alter stage with interrupt shield
`timescale 1ns/1ps
module nfa_top
   import nfa_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire nfa_req_t alt_req,
   input wire logic instr_issue,
   input wire logic q_load,
   input wire logic [WORD_W-1:0] q_value,
   input wire logic allow_op,
   input wire logic stall_op,
   input wire logic irq_pend,
   output nfa_sub_t sub_out,
   output logic [WORD_W-1:0] wb_data,
   output logic wb_en,
   output logic q_valid,
   output logic [WORD_W-1:0] q_out,
   output logic irq_take,
   output logic irq_enabled
);
   typedef struct packed
   {
      nfa_state_t st;
      nfa_sub_t sub;
      logic [WORD_W-1:0] wb;
      logic wb_en;
      logic q_valid;
      logic [WORD_W-1:0] q;
      logic q_zero;
      logic irq_en;
      logic irq_take;
   } nfa_state_s_t;

   logic rst_meta_ff;
   logic rst_sync_ff;
   nfa_state_s_t st_ff;
   nfa_state_s_t nxt_st;
   nfa_sub_t calc_sub;
   logic [WORD_W-1:0] calc_wb;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   nfa_calc u_calc
   (
      .req(alt_req),
      .sub(calc_sub),
      .wb(calc_wb)
   );

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.wb_en = 1'b0;
      nxt_st.irq_take = 1'b0;
      // the alter clears on the successor's issue; never lingers
      if (instr_issue && st_ff.st == NFA_ARMED)
      begin
         nxt_st.st = NFA_IDLE;
         nxt_st.sub = '0;
         if (st_ff.q_valid)
         begin
            nxt_st.q_valid = 1'b0;
         end
      end
      else if (instr_issue && st_ff.q_valid)
      begin
         nxt_st.q_valid = 1'b0;
      end
      case (st_ff.st)
         NFA_IDLE, NFA_ARMED:
         begin
            if (alt_req.valid)
            begin
               nxt_st.st = NFA_ARMED;
               nxt_st.sub = calc_sub;
               nxt_st.sub.range_zero = (alt_req.op == NFA_OP_BIT) && st_ff.q_valid && st_ff.q_zero;
               nxt_st.wb = calc_wb;
               nxt_st.wb_en = 1'b1;
               // q stays pending across the alter for its successor
               nxt_st.q_valid = st_ff.q_valid;
            end
         end
         default:
         begin
            nxt_st.st = NFA_IDLE;
         end
      endcase
      if (q_load)
      begin
         nxt_st.q_valid = 1'b1;
         nxt_st.q = q_value;
         nxt_st.q_zero = (q_value == '0);
      end
      if (allow_op)
      begin
         nxt_st.irq_en = 1'b1;
      end
      else if (stall_op)
      begin
         nxt_st.irq_en = 1'b0;
      end
      // shield: no branch while an alter waits for its successor
      nxt_st.irq_take = irq_pend && nxt_st.irq_en && st_ff.irq_en && nxt_st.st != NFA_ARMED
         && st_ff.st != NFA_ARMED;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '{st: NFA_IDLE, irq_en: 1'b1, default: '0};
      end
      else if (!rst_sync_ff)
      begin
         st_ff <= '{st: NFA_IDLE, irq_en: 1'b1, default: '0};
      end
      else if (clk_en)
      begin
         st_ff <= nxt_st;
      end
   end

   assign sub_out = st_ff.sub;
   assign wb_data = st_ff.wb;
   assign wb_en = st_ff.wb_en;
   assign q_valid = st_ff.q_valid;
   assign q_out = st_ff.q;
   assign irq_take = st_ff.irq_take;
   assign irq_enabled = st_ff.irq_en;

   logic run;
   assign run = rst_sync_ff && clk_en;

   shield_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      st_ff.st == NFA_ARMED |-> !irq_take)
      else $error("interrupt taken after alter");
   shield_next_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid |=> !irq_take)
      else $error("interrupt taken with alter pending");
   dest_two_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && alt_req.op == NFA_OP_DEST && alt_req.two_op
      |=> sub_out.dest == 9'($past(alt_req.src[8:0]) + $past(alt_req.dest[8:0])))
      else $error("dest alter sum wrong");
   dest_one_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && alt_req.op == NFA_OP_DEST && !alt_req.two_op
      |=> sub_out.dest == $past(alt_req.dest[8:0]))
      else $error("dest alter pass wrong");
   post_adj_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && !alt_req.two_op |=> wb_en && wb_data == $past(alt_req.dest))
      else $error("post adjust wrong");
   post_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && alt_req.two_op |=> wb_en
      && wb_data == $past(alt_req.dest) + {{23{$past(alt_req.src[17])}}, $past(alt_req.src[17:9])})
      else $error("auto index adjust wrong");
   bit_fld_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && alt_req.op == NFA_OP_BIT && !alt_req.two_op
      |=> sub_out.dest == $past(alt_req.dest[13:5]))
      else $error("bit alter field wrong");
   bit_two_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && alt_req.op == NFA_OP_BIT && alt_req.two_op
      |=> sub_out.dest == 9'($past(alt_req.src[8:0]) + $past(alt_req.dest[13:5])))
      else $error("bit alter sum wrong");
   byte_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && alt_req.op == NFA_OP_BYTE
      |=> sub_out.sel_en && sub_out.sel == $past(alt_req.dest[1:0]))
      else $error("byte select wrong");
   byte_src_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && alt_req.op == NFA_OP_BYTE && alt_req.two_op
      |=> sub_out.src_en && sub_out.src == 9'($past(alt_req.src[8:0]) + $past(alt_req.dest[10:2])))
      else $error("byte alter source wrong");
   range_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && alt_req.op == NFA_OP_BIT && q_valid && q_out == '0 |=> sub_out.range_zero)
      else $error("bit range not zeroed");
   one_shot_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && instr_issue && !alt_req.valid && st_ff.st == NFA_ARMED |=> st_ff.st == NFA_IDLE)
      else $error("alter persisted");
   q_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && alt_req.valid && q_valid && !instr_issue |=> q_valid)
      else $error("q consumed by alter");
   allow_en_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && allow_op |=> irq_enabled)
      else $error("allow ignored");
   stall_dis_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      run && stall_op && !allow_op |=> !irq_enabled)
      else $error("stall ignored");
   take_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_ff)
      $past(run) && irq_take |-> $past(irq_pend) && $past(irq_enabled))
      else $error("interrupt taken while held off");
   c_chain: cover property (@(posedge sys_clk) alt_req.valid ##1 alt_req.valid);
   c_stall: cover property (@(posedge sys_clk) !irq_enabled ##1 irq_enabled);
   c_bitq: cover property (@(posedge sys_clk) sub_out.range_zero);
   c_irq: cover property (@(posedge sys_clk) irq_take);
endmodule : nfa_top

// *** bench/test_nfa_top.sv ***
// self-checking bench for the next-instruction field alter stage
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module test_nfa_top
   import nfa_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   nfa_req_t alt_req = '0;
   logic instr_issue = 1'b0;
   logic q_load = 1'b0;
   logic [WORD_W-1:0] q_value = '0;
   logic allow_op = 1'b0;
   logic stall_op = 1'b0;
   logic irq_pend = 1'b0;
   nfa_sub_t sub_out;
   logic [WORD_W-1:0] wb_data;
   logic wb_en;
   logic q_valid;
   logic [WORD_W-1:0] q_out;
   logic irq_take;
   logic irq_enabled;
   int n_fail = 0;
   int comparisons = 0;
   nfa_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .alt_req(alt_req),
      .instr_issue(instr_issue), .q_load(q_load), .q_value(q_value), .allow_op(allow_op),
      .stall_op(stall_op), .irq_pend(irq_pend), .sub_out(sub_out), .wb_data(wb_data), .wb_en(wb_en),
      .q_valid(q_valid), .q_out(q_out), .irq_take(irq_take), .irq_enabled(irq_enabled));
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   // inputs move 1 ns after the edge, well clear of sampling
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask : step
   task automatic alter(input nfa_op_t op, input logic two, input logic [31:0] d, input logic [31:0] s);
      alt_req = '{valid: 1'b1, op: op, two_op: two, dest: d, src: s};
      step();
      alt_req.valid = 1'b0;
   endtask : alter
   task automatic run(input nfa_op_t op, input logic two, input logic [31:0] d, input logic [31:0] s,
      input nfa_sub_t e_sub, input logic [31:0] e_wb);
      alter(op, two, d, s);
      `CHK(wb_en, 1'b1)
      `CHK(wb_data, e_wb)
      `CHK(sub_out, e_sub)
   endtask : run
   task automatic issue();
      instr_issue = 1'b1;
      step();
      instr_issue = 1'b0;
      `CHK({sub_out.dest_en, sub_out.src_en, sub_out.sel_en}, 3'h0)
   endtask : issue
   // irq_take rises only once the shield lifts, so poll a few cycles rather than one fixed slot
   task automatic wait_take();
      int i;
      for (i = 0; i < 6 && irq_take !== 1'b1; i++)
         step();
      `CHK(irq_take, 1'b1)
   endtask : wait_take
   task automatic t_dest();
      run(NFA_OP_DEST, 1'b1, 32'h0000_0005, 32'h0003_FE03, '{1'b1, 9'h008, 1'b0, 9'h000, 1'b0, 2'h0, 1'b0},
         32'h0000_0004);
      issue();
      run(NFA_OP_DEST, 1'b0, 32'h0000_0BFF, 32'h0000_0000, '{1'b1, 9'h1FF, 1'b0, 9'h000, 1'b0, 2'h0, 1'b0},
         32'h0000_0BFF);
      issue();
   endtask : t_dest
   task automatic t_bit();
      q_load = 1'b1;
      q_value = 32'h0000_0000;
      step();
      q_load = 1'b0;
      run(NFA_OP_BIT, 1'b1, 32'h0000_3FE7, 32'h0000_0202, '{1'b1, 9'h001, 1'b0, 9'h000, 1'b0, 2'h0, 1'b1},
         32'h0000_3FE8);
      `CHK(q_valid, 1'b1)
      `CHK(q_out, 32'h0000_0000)
      issue();
   endtask : t_bit
   task automatic t_byte();
      run(NFA_OP_BYTE, 1'b0, 32'h0000_07FE, 32'h0000_0000, '{1'b0, 9'h000, 1'b1, 9'h1FF, 1'b1, 2'h2, 1'b0},
         32'h0000_07FE);
      issue();
      run(NFA_OP_BYTE, 1'b1, 32'h0000_0413, 32'h0000_03F0, '{1'b0, 9'h000, 1'b1, 9'h0F4, 1'b1, 2'h3, 1'b0},
         32'h0000_0414);
      issue();
   endtask : t_byte
   task automatic t_back();
      // valid stays high into the second alter: one assignment per time step
      alt_req = '{valid: 1'b1, op: NFA_OP_DEST, two_op: 1'b1, dest: 32'h0000_0001, src: 32'h0000_0010};
      step();
      `CHK(sub_out.dest, 9'h011)
      `CHK(wb_data, 32'h0000_0001)
      run(NFA_OP_DEST, 1'b0, 32'h0000_0077, 32'h0000_0000, '{1'b1, 9'h077, 1'b0, 9'h000, 1'b0, 2'h0, 1'b0},
         32'h0000_0077);
      issue();
   endtask : t_back
   task automatic t_shield();
      irq_pend = 1'b1;
      alter(NFA_OP_BIT, 1'b0, 32'h0000_0020, 32'h0000_0000);
      `CHK(irq_take, 1'b0)
      `CHK(sub_out.dest, 9'h001)
      `CHK(sub_out.range_zero, 1'b0)
      issue();
      wait_take();
      irq_pend = 1'b0;
      step();
   endtask : t_shield
   task automatic t_stall();
      stall_op = 1'b1;
      step();
      stall_op = 1'b0;
      irq_pend = 1'b1;
      repeat (3)
      begin
         step();
         `CHK(irq_take, 1'b0)
      end
      `CHK(irq_enabled, 1'b0)
      allow_op = 1'b1;
      step();
      allow_op = 1'b0;
      `CHK(irq_enabled, 1'b1)
      wait_take();
      irq_pend = 1'b0;
      step();
   endtask : t_stall
   // request held across the frozen edge, taken once enable returns
   task automatic t_freeze();
      clk_en = 1'b0;
      alt_req = '{valid: 1'b1, op: NFA_OP_DEST, two_op: 1'b1, dest: 32'h0000_0005, src: 32'h0000_0003};
      step();
      `CHK(wb_en, 1'b0)
      `CHK(sub_out.dest_en, 1'b0)
      clk_en = 1'b1;
      step();
      alt_req.valid = 1'b0;
      `CHK(sub_out.dest, 9'h008)
      `CHK(wb_data, 32'h0000_0005)
      issue();
   endtask : t_freeze
   // second reset in mid-run must bring interrupts back on
   task automatic t_restart();
      stall_op = 1'b1;
      step();
      stall_op = 1'b0;
      alter(NFA_OP_DEST, 1'b0, 32'h0000_0005, 32'h0000_0000);
      `CHK(irq_enabled, 1'b0)
      rst_n = 1'b0;
      step();
      `CHK(irq_enabled, 1'b1)
      `CHK(sub_out.dest_en, 1'b0)
      rst_n = 1'b1;
      repeat (3) step();
      `CHK(irq_enabled, 1'b1)
      `CHK(wb_en, 1'b0)
   endtask : t_restart
   task automatic conclude();
      if (n_fail == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   initial
   begin
      #20000;
      n_fail++;
      conclude();
   end
   initial
   begin
      repeat (2) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      repeat (4) step();
      `CHK(irq_enabled, 1'b1)
      `CHK(wb_en, 1'b0)
      t_dest();
      t_freeze();
      t_bit();
      t_byte();
      t_back();
      t_shield();
      t_stall();
      t_restart();
      conclude();
   end
endmodule : test_nfa_top
